// ==== inc/fault_status_map.svh ====
`ifndef FAULT_STATUS_MAP_SVH
`define FAULT_STATUS_MAP_SVH
// register addresses (6-bit serial frame address)
`define ADDR_GENERAL_FAULT   6'h12
`define ADDR_FEEDBACK_FIRST 6'h13
`define ADDR_FEEDBACK_LAST  6'h18
// general fault field positions
`define TW_LSB              1
`define TSD_LSB             7
`define OVERVOLT_BIT        13
`define LOWINH_BIT          14
`define CHARGE_PUMP_LOW_FLAG_BIT           15
// feedback field positions
`define CF_LSB              1
`define AUXUV_BIT           15
// reset values and the all-outputs disable mask
`define FLAGS_RESET         6'h00
`define ALL_OUTPUTS         6'h3F
`define WORD_RESET          16'h0000
`define CF_RESET            10'h000
`endif

// ==== inc/fault_status_pkg.sv ====
package fault_status_pkg;
  typedef logic [5:0]  out_vec_t;
  typedef logic [9:0]  cf_t;
  typedef logic [15:0] word_t;
  typedef logic [5:0]  addr_t;

  typedef struct packed {
    out_vec_t tw;
    out_vec_t tsd;
    out_vec_t off_latch;
    logic     overvolt;
    logic     low_inhibit;
    logic     cp_low;
    logic     aux_uv;
    cf_t [5:0] cf;
    word_t    rdata;
    logic     rvalid;
  } state_s;
endpackage

// ==== logic/fault_and_current_feedback_status.sv ====
`timescale 1ns/100ps
`include "fault_status_map.svh"
// Overview of operation
// - per-output thermal warning flag, fault bits 1..6, set above warning level
// - warning flag holds while hot; clears by read-and-clear once cooled
// - per-output shutdown flag, fault bits 7..12, set above shutdown level
// - scope select 0 disables offending output; 1 disables all outputs
// - shutdown flag holds while hot; clears by read-and-clear once cooled
// - shut-down output stays off until its shutdown flag is read-and-cleared
// - supply overvoltage flag at fault bit 13
// - supply low-voltage inhibit flag at fault bit 14
// - charge pump low flag at bit 15, latched after condition ends
// - other fault codes may accompany charge pump low; host tolerates them
// - fault bits 1..15 reset to 0 and clear on read-and-clear
// - general fault register lives at address 12H
// - six feedback registers 13H..18H, 10-bit value in bits 10..1
// - feedback value read-only, resets to 0, unaffected by read-and-clear
// - aux rail undervoltage flag at bit 15 of 13H only
// - host selects plain read or read-and-clear by frame operation code
// - aux undervoltage flag set on 3.3 V rail falling, cleared by read-and-clear

module fault_and_current_feedback_status (
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic                       clk_en,
  input  wire logic                       rd_strobe,
  input  wire logic                       rd_clear,
  input  wire fault_status_pkg::addr_t    rd_addr,
  output logic                            rd_valid,
  output fault_status_pkg::word_t         rd_data,
  input  wire fault_status_pkg::out_vec_t over_warning,
  input  wire fault_status_pkg::out_vec_t over_warning_release,
  input  wire fault_status_pkg::out_vec_t over_shutdown,
  input  wire fault_status_pkg::out_vec_t over_shutdown_release,
  input  wire logic                       shutdown_scope_select,
  input  wire logic                       supply_over,
  input  wire logic                       supply_low,
  input  wire logic                       charge_pump_low,
  input  wire logic                       aux_rail_low,
  input  wire logic                       cf_update,
  input  wire fault_status_pkg::cf_t      cf_sample [6],
  output fault_status_pkg::out_vec_t      output_disable,
  output fault_status_pkg::out_vec_t      thermal_warning_flag,
  output fault_status_pkg::out_vec_t      thermal_shutdown_flag,
  output logic                            supply_overvoltage_flag,
  output logic                            supply_low_inhibit_flag,
  output logic                            charge_pump_low_flag,
  output logic                            aux_rail_undervoltage_flag
);

  // ************************************************
  // state and helper functions
  // ************************************************
  fault_status_pkg::state_s state_reg;
  fault_status_pkg::state_s state_next;

  // assemble the general fault word
  function automatic fault_status_pkg::word_t fault_word(input fault_status_pkg::state_s s);
    fault_status_pkg::word_t w;
    w = `WORD_RESET;
    w[`TW_LSB +: 6]   = s.tw;
    w[`TSD_LSB +: 6]  = s.tsd;
    w[`OVERVOLT_BIT]  = s.overvolt;
    w[`LOWINH_BIT]    = s.low_inhibit;
    w[`CHARGE_PUMP_LOW_FLAG_BIT]     = s.cp_low;
    return w;
  endfunction

  // decode a feedback address into its output index
  function automatic logic [2:0] cf_index(input fault_status_pkg::addr_t a);
    fault_status_pkg::addr_t d;
    d = a - `ADDR_FEEDBACK_FIRST;
    return d[2:0];
  endfunction

  logic hit_fault;
  logic hit_cf;
  logic clr_fault;
  logic clr_aux;
  fault_status_pkg::word_t fault_now;

  // fault word as it stands, for the read-back check
  assign fault_now = fault_word(state_reg);

  // ************************************************
  // request decode
  // ************************************************
  // address decode and clear qualifiers
  always_comb begin
    hit_fault = rd_strobe && (rd_addr == `ADDR_GENERAL_FAULT);
    hit_cf    = rd_strobe && (rd_addr >= `ADDR_FEEDBACK_FIRST)
                && (rd_addr <= `ADDR_FEEDBACK_LAST);
    clr_fault = hit_fault && rd_clear;
    clr_aux   = rd_strobe && rd_clear && (rd_addr == `ADDR_FEEDBACK_FIRST);
  end

  // ************************************************
  // next state
  // ************************************************
  // next-state: flags, latches, feedback, read answer
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    // read answer uses pre-clear values
    if (hit_fault) begin
      state_next.rdata = fault_word(state_reg);
    end else if (hit_cf) begin
      state_next.rdata = `WORD_RESET;
      state_next.rdata[`CF_LSB +: 10] = state_reg.cf[cf_index(rd_addr)];
      if (rd_addr == `ADDR_FEEDBACK_FIRST) begin
        state_next.rdata[`AUXUV_BIT] = state_reg.aux_uv;
      end
    end else begin
      state_next.rdata = `WORD_RESET;
    end
    state_next.rvalid = rd_strobe;
    // clear of fault flags; hardware hold/set below wins
    if (clr_fault) begin
      state_next.tw          = `FLAGS_RESET;
      state_next.tsd         = `FLAGS_RESET;
      state_next.overvolt    = 1'b0;
      state_next.low_inhibit = 1'b0;
      state_next.cp_low      = 1'b0;
    end
    if (clr_aux) begin
      state_next.aux_uv = 1'b0;
    end
    // flags held while above release level, set above threshold
    state_next.tw  = state_next.tw | over_warning
                     | (state_reg.tw & over_warning_release);
    state_next.tsd = state_next.tsd | over_shutdown
                     | (state_reg.tsd & over_shutdown_release);
    state_next.overvolt    = state_next.overvolt | supply_over;
    state_next.low_inhibit = state_next.low_inhibit | supply_low;
    state_next.cp_low      = state_next.cp_low | charge_pump_low;
    state_next.aux_uv      = state_next.aux_uv | aux_rail_low;
    // outputs stay off until their shutdown flag is cleared
    state_next.off_latch = state_next.tsd;
    // feedback value is read-only, only sampled
    if (cf_update) begin
      for (int i = 0; i < 6; i++) begin
        state_next.cf[i] = cf_sample[i];
      end
    end
  end

  // ************************************************
  // state register
  // ************************************************
  // state register with clock enable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  // outputs
  always_comb begin
    rd_valid = state_reg.rvalid;
    rd_data  = state_reg.rdata;
    output_disable = shutdown_scope_select && (state_reg.off_latch != `FLAGS_RESET)
                     ? `ALL_OUTPUTS : state_reg.off_latch;
    thermal_warning_flag       = state_reg.tw;
    thermal_shutdown_flag      = state_reg.tsd;
    supply_overvoltage_flag    = state_reg.overvolt;
    supply_low_inhibit_flag    = state_reg.low_inhibit;
    charge_pump_low_flag       = state_reg.cp_low;
    aux_rail_undervoltage_flag = state_reg.aux_uv;
  end

  // ************************************************
  // assertions
  // ************************************************

  // thermal flags set on their condition
  a_tw_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && over_warning[0] |=> state_reg.tw[0])
    else $error("warning flag not set");
  a_tw_vec: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en |=> (state_reg.tw & $past(over_warning)) == $past(over_warning))
    else $error("warning vector not set");
  a_tw_no_spur: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !over_warning[4] && !state_reg.tw[4] |=> !state_reg.tw[4])
    else $error("warning flag set without cause");
  a_tsd_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && over_shutdown[1] |=> thermal_shutdown_flag[1] && output_disable[1])
    else $error("shutdown flag not set");
  a_tsd_vec: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en |=> (state_reg.tsd & $past(over_shutdown)) == $past(over_shutdown))
    else $error("shutdown vector not set");
  a_tsd_no_spur: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !over_shutdown[4] && !state_reg.tsd[4] |=> !state_reg.tsd[4])
    else $error("shutdown flag set without cause");

  // thermal flags hold while hot, clear once cooled
  a_tw_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && state_reg.tw[2] && over_warning_release[2] |=> state_reg.tw[2])
    else $error("warning flag dropped while hot");
  a_tsd_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && state_reg.tsd[1] && over_shutdown_release[1] |=> state_reg.tsd[1])
    else $error("shutdown flag dropped while hot");
  a_tw_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && clr_fault && (over_warning | over_warning_release) == `FLAGS_RESET
    |=> thermal_warning_flag == `FLAGS_RESET)
    else $error("warning flag not cleared");
  a_tsd_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && clr_fault && (over_shutdown | over_shutdown_release) == `FLAGS_RESET
    |=> thermal_shutdown_flag == `FLAGS_RESET)
    else $error("shutdown flag not cleared");

  // shutdown scope and latched-off outputs
  a_scope_all: assert property (@(posedge sys_clk) disable iff (!resetn)
    shutdown_scope_select && (state_reg.tsd != 6'h00) |-> output_disable == `ALL_OUTPUTS)
    else $error("global shutdown missing");
  a_scope_one: assert property (@(posedge sys_clk) disable iff (!resetn)
    !shutdown_scope_select |-> output_disable == state_reg.tsd)
    else $error("local shutdown wrong");
  a_scope_none: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_reg.tsd == `FLAGS_RESET |-> output_disable == `FLAGS_RESET)
    else $error("output disabled without shutdown");
  a_off_cover: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_reg.tsd & ~output_disable) == `FLAGS_RESET)
    else $error("shut down output still enabled");
  a_off_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && state_reg.off_latch[1] && !clr_fault |=> state_reg.off_latch[1])
    else $error("output released before clear");

  // supply and charge pump flags
  a_ovolt_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && supply_over |=> supply_overvoltage_flag)
    else $error("overvoltage flag not set");
  a_lowinh_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && supply_low |=> supply_low_inhibit_flag)
    else $error("low inhibit flag not set");
  a_charge_pump_low_flag_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && charge_pump_low |=> charge_pump_low_flag)
    else $error("charge pump flag not set");
  a_charge_pump_low_flag_latch: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && charge_pump_low ##1 (!clr_fault || !clk_en) |=> charge_pump_low_flag)
    else $error("charge pump flag lost");
  a_clear_fault: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && clr_fault && !supply_over |=> !supply_overvoltage_flag)
    else $error("overvoltage not cleared");
  a_lowinh_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && clr_fault && !supply_low |=> !supply_low_inhibit_flag)
    else $error("low inhibit not cleared");
  a_charge_pump_low_flag_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && clr_fault && !charge_pump_low |=> !charge_pump_low_flag)
    else $error("charge pump flag not cleared");
  a_aux_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && aux_rail_low |=> aux_rail_undervoltage_flag)
    else $error("aux flag not set");
  a_aux_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && clr_aux && !aux_rail_low |=> !aux_rail_undervoltage_flag)
    else $error("aux flag not cleared");

  // read answer contents and timing
  a_read_preclear: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && hit_fault |=> rd_valid && rd_data == $past(fault_now))
    else $error("read value not pre-clear");
  a_fault_map: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && hit_fault |=> rd_data[`TSD_LSB +: 6] == $past(state_reg.tsd))
    else $error("shutdown field misplaced");
  a_cf_value: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && hit_cf && rd_addr == `ADDR_FEEDBACK_FIRST
    |=> rd_data[`CF_LSB +: 10] == $past(state_reg.cf[0]))
    else $error("feedback value misplaced");
  a_cf_reserved: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && hit_cf |=> rd_data[14:11] == 4'h0)
    else $error("reserved bits nonzero");
  a_aux_only_first: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && hit_cf && rd_addr != `ADDR_FEEDBACK_FIRST |=> !rd_data[15])
    else $error("aux flag outside first register");
  a_cf_readonly: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !cf_update |=> $stable(state_reg.cf))
    else $error("feedback value changed by access");
  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && rd_strobe && !hit_fault && !hit_cf |=> rd_data == `WORD_RESET)
    else $error("unmapped address answered nonzero");
  a_valid_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && rd_strobe |=> rd_valid)
    else $error("access not answered");
  a_valid_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !rd_strobe |=> !rd_valid)
    else $error("answer without access");
  a_parity_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_valid |-> !rd_data[0])
    else $error("parity slot not zero");

  // clock enable low freezes the whole state register
  a_state_freeze: assert property (@(posedge sys_clk) disable iff (!resetn)
    !clk_en |=> $stable(state_reg))
    else $error("state moved while frozen");

  // main scenarios reached
  c_read_clear: cover property (@(posedge sys_clk) clr_fault && state_reg.tsd != 6'h00);
  c_global_off: cover property (@(posedge sys_clk)
    shutdown_scope_select && output_disable == `ALL_OUTPUTS);
  c_aux_read: cover property (@(posedge sys_clk) clr_aux && state_reg.aux_uv);
  c_cf_load: cover property (@(posedge sys_clk) clk_en && cf_update);
  c_frozen_read: cover property (@(posedge sys_clk) !clk_en && rd_strobe);

endmodule

// ==== bench/status_host_model.sv ====
`timescale 1ns/100ps
// ****
// host side of the status registers
// ****
module status_host_model (
  input  wire logic                    sys_clk,
  output logic                         rd_strobe,
  output logic                         rd_clear,
  output fault_status_pkg::addr_t      rd_addr,
  input  wire logic                    rd_valid,
  input  wire fault_status_pkg::word_t rd_data
);
  int ma_x100;
  // idle request lines at time zero
  initial begin
    rd_strobe = 1'b0;
    rd_clear  = 1'b0;
    rd_addr   = 6'h00;
  end
  // one access: strobe one cycle, take the word with valid
  task automatic access(input fault_status_pkg::addr_t a, input logic clr,
                        output fault_status_pkg::word_t d);
    @(posedge sys_clk);
    rd_strobe <= 1'b1;
    rd_clear  <= clr;
    rd_addr   <= a;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    #1;
    d = (rd_valid === 1'b1) ? rd_data : 16'hDEAD;
    ma_x100 = int'(d[10:1]) * 625;
  endtask
endmodule

// ==== bench/fault_and_current_feedback_status_tb.sv ====
`timescale 1ns/100ps
// ****
// status register bench
// ****
module fault_and_current_feedback_status_tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic rd_strobe, rd_clear, rd_valid;
  fault_status_pkg::addr_t rd_addr;
  fault_status_pkg::word_t rd_data, d;
  fault_status_pkg::out_vec_t ow = '0, owr = '0, os = '0, osr = '0, dis;
  logic scope = 1'b0, s_over = 1'b0, s_low = 1'b0, cp = 1'b0, aux = 1'b0, upd = 1'b0;
  logic en = 1'b1, ovf, lif, cpf, auxf;
  fault_status_pkg::out_vec_t twf, tsf;
  fault_status_pkg::cf_t cf [6] = '{default: 10'h000};
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // clock and hang guard
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end
  status_host_model host (.sys_clk, .rd_strobe, .rd_clear, .rd_addr, .rd_valid, .rd_data);
  fault_and_current_feedback_status dut (.sys_clk, .resetn, .clk_en(en), .rd_strobe,
    .rd_clear, .rd_addr, .rd_valid, .rd_data, .over_warning(ow), .over_warning_release(owr),
    .over_shutdown(os), .over_shutdown_release(osr), .shutdown_scope_select(scope),
    .supply_over(s_over), .supply_low(s_low), .charge_pump_low(cp), .aux_rail_low(aux),
    .cf_update(upd), .cf_sample(cf), .output_disable(dis), .thermal_warning_flag(twf),
    .thermal_shutdown_flag(tsf), .supply_overvoltage_flag(ovf),
    .supply_low_inhibit_flag(lif), .charge_pump_low_flag(cpf),
    .aux_rail_undervoltage_flag(auxf));
  task automatic chk(input fault_status_pkg::word_t got, input fault_status_pkg::word_t exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // warning and shutdown flags, hold while hot, latched off output
  task automatic t_thermal();
    @(posedge sys_clk);
    {ow, owr, os, osr} <= {6'h05, 6'h05, 6'h02, 6'h02};
    @(posedge sys_clk);
    {ow, os} <= '0;
    host.access(6'h12, 1'b1, d);
    chk(d, 16'h010A);
    chk({10'h000, dis}, 16'h0002);
    chk({4'h0, twf, tsf}, 16'h0142);
    host.access(6'h12, 1'b1, d);
    chk(d, 16'h010A);
    @(posedge sys_clk);
    {owr, osr} <= '0;
    #1 chk({10'h000, dis}, 16'h0002);
    host.access(6'h12, 1'b1, d);
    chk(d, 16'h010A);
    host.access(6'h12, 1'b0, d);
    chk(d, 16'h0000);
    chk({10'h000, dis}, 16'h0000);
    @(posedge sys_clk);
    {scope, os, osr} <= {1'b1, 6'h10, 6'h10};
    @(posedge sys_clk);
    {os, osr} <= '0;
    @(posedge sys_clk);
    #1 chk({10'h000, dis}, 16'h003F);
    host.access(6'h12, 1'b1, d);
    chk(d, 16'h0800);
    @(posedge sys_clk);
    scope <= 1'b0;
  endtask
  // supply and charge pump flags latch until read-and-clear
  task automatic t_supply();
    @(posedge sys_clk);
    {s_over, s_low, cp} <= 3'b111;
    @(posedge sys_clk);
    {s_over, s_low, cp} <= 3'b000;
    #1 chk({12'h000, ovf, lif, cpf, auxf}, 16'h000E);
    host.access(6'h12, 1'b1, d);
    chk(d, 16'hE000);
    host.access(6'h12, 1'b0, d);
    chk(d, 16'h0000);
    @(posedge sys_clk);
    {en, s_over} <= 2'b01;
    host.access(6'h12, 1'b1, d);
    chk(d, 16'hDEAD);
    @(posedge sys_clk);
    {en, s_over} <= 2'b10;
    host.access(6'h12, 1'b0, d);
    chk(d, 16'h0000);
  endtask
  // feedback words, aux flag only in the first, reserved bits zero
  task automatic t_feedback();
    host.access(6'h13, 1'b0, d);
    chk(d, 16'h0000);
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) cf[i] <= 10'h3FF - 10'(i * 99);
    {upd, aux} <= 2'b11;
    @(posedge sys_clk);
    {upd, aux} <= 2'b00;
    #1 chk({15'h0000, auxf}, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      host.access(6'h13 + 6'(i), 1'b1, d);
      chk(d, {i == 0, 4'h0, 10'h3FF - 10'(i * 99), 1'b0});
      if (i == 0) begin
        chk(host.ma_x100[31:16], 16'h0009);
        chk(host.ma_x100[15:0], 16'hC18F);
      end
    end
    host.access(6'h13, 1'b0, d);
    chk(d, 16'h07FE);
    host.access(6'h20, 1'b1, d);
    chk(d, 16'h0000);
  endtask
  // reset, then each scenario in turn
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    host.access(6'h12, 1'b0, d);
    chk(d, 16'h0000);
    t_thermal();
    t_supply();
    t_feedback();
    final_report();
  end
endmodule
